/* File: hdl/tds_thermal_status.sv */
// Thermal protection and device information status registers behind the serial port
`timescale 1ns/10ps
`include "tds_thermal_status_regs.svh"
module tds_thermal_status #(
  parameter int          NMOD           = 3,
  parameter logic [31:0] SHORT_WAIT_CYC = `TDS_SHORT_WAIT_CYC,
  parameter logic [31:0] LONG_WAIT_CYC  = `TDS_LONG_WAIT_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   soft_reset,
  input  wire logic                   restart,
  input  wire logic                   acc_valid,
  input  wire logic [`TDS_ADDR_W-1:0] acc_addr,
  input  wire logic                   acc_clear,
  input  wire logic                   acc_crc_bad,
  output logic      [15:0]            rd_data,
  output logic                        rd_valid,
  input  wire logic                   prewarn_evt,
  input  wire logic [NMOD-1:0]        module_overheat_evt,
  input  wire logic [NMOD-1:0]        module_reenable,
  input  wire logic                   overheat2_evt,
  input  wire logic                   overheat2_chain_break,
  input  wire logic                   crc_enabled,
  input  wire logic                   crc_error_evt,
  input  wire logic                   crc_toggle_seq,
  input  wire logic                   prior_fail_evt,
  input  wire logic                   prior_sleep_evt,
  input  wire logic                   development_mode,
  input  wire logic                   watchdog_failure_count_evt,
  input  wire logic                   wd_count_dec,
  input  wire logic                   wd_count_clr,
  input  wire logic                   spi_invalid_evt,
  input  wire logic                   failure_evt,
  output logic      [NMOD-1:0]        module_off,
  output logic                        fail_safe_req,
  output logic                        overheat2_recover,
  output logic                        overheat2_long_wait
);

  typedef struct packed {
    logic            overheat_safe_state_flag;
    logic            second_level_overheat_flag;
    logic            first_level_overheat_flag;
    logic            overheat_prewarning_flag;
    logic            crc_enabled;
    logic            crc_fail;
    logic [1:0]      prior_state;
    logic            development_mode_flag;
    logic [1:0]      watchdog_failure_count;
    logic            spi_fail;
    logic            failure;
    logic [4:0]      overheat2_run;
    logic [NMOD-1:0] module_off;
    logic            fail_safe;
    logic [15:0]     rd_data;
    logic            rd_valid;
  } tds_state_type;

  tds_state_type   st_reg;
  tds_state_type   st_next;
  logic [NMOD-1:0] module_off_next;
  logic            thermal_sel;
  logic            devinfo_sel;
  logic            acc_ok;
  logic            clr_thermal;
  logic            clr_devinfo;
  logic            wipe;
  logic            safe_set;
  logic [15:0]     thermal_view;
  logic [15:0]     devinfo_view;

  assign thermal_sel = (acc_addr == `TDS_OFF_THERMAL);
  assign devinfo_sel = (acc_addr == `TDS_OFF_DEVINFO);

  // CRC field ignored on device info accesses only
  // A frame with a bad CRC is refused, except a device info read, which is always answered
  assign acc_ok = acc_valid & (~acc_crc_bad | devinfo_sel);

  assign clr_thermal = acc_ok & acc_clear & thermal_sel;
  assign clr_devinfo = acc_ok & acc_clear & devinfo_sel;

  // Soft reset wipes the bank like power-on; restart is handled field by field
  assign wipe = soft_reset;

  assign safe_set = overheat2_evt & (st_reg.overheat2_run >= `TDS_OVERHEAT_SAFE_STATE_FLAG_LIMIT);

  always_comb begin
    thermal_view = 16'h0000;
    thermal_view[`TDS_THERM_SAFE_BIT] = st_reg.overheat_safe_state_flag;
    thermal_view[`TDS_THERM_SECOND_LEVEL_OVERHEAT_FLAG_BIT] = st_reg.second_level_overheat_flag;
    thermal_view[`TDS_THERM_FIRST_LEVEL_OVERHEAT_FLAG_BIT] = st_reg.first_level_overheat_flag;
    thermal_view[`TDS_THERM_PREW_BIT] = st_reg.overheat_prewarning_flag;
  end

  always_comb begin
    devinfo_view = 16'h0000;
    devinfo_view[`TDS_DEV_CRC_EN_BIT] = st_reg.crc_enabled;
    devinfo_view[`TDS_DEV_CRC_FAIL_BIT] = st_reg.crc_fail;
    devinfo_view[`TDS_DEV_PRE_HI:`TDS_DEV_PRE_LO] = st_reg.prior_state;
    devinfo_view[`TDS_DEV_DEVMODE_BIT] = st_reg.development_mode_flag;
    devinfo_view[`TDS_DEV_WD_HI:`TDS_DEV_WD_LO] = st_reg.watchdog_failure_count;
    devinfo_view[`TDS_DEV_SPI_FAIL_BIT] = st_reg.spi_fail;
    devinfo_view[`TDS_DEV_FAILURE_BIT] = st_reg.failure;
  end

  // Each module is shut down on its own overheat event and nothing else
  genvar gi;
  generate
    for (gi = 0; gi < NMOD; gi = gi + 1) begin : g_module
      assign module_off_next[gi] = module_overheat_evt[gi] |
                                   (st_reg.module_off[gi] & ~module_reenable[gi]);
    end
  endgenerate

  always_comb begin
    st_next = st_reg;

    // Read answer carries the value before any clear of this same access
    st_next.rd_valid = acc_ok;
    if (acc_ok && thermal_sel) begin
      st_next.rd_data = thermal_view;
    end else if (acc_ok && devinfo_sel) begin
      st_next.rd_data = devinfo_view;
    end else begin
      st_next.rd_data = 16'h0000;
    end

    // Thermal flags: clear first, then events, so a same-cycle event wins
    // sticky flags
    if (clr_thermal) begin
      st_next.overheat_safe_state_flag   = 1'b0;
      st_next.second_level_overheat_flag = 1'b0;
      st_next.first_level_overheat_flag  = 1'b0;
      st_next.overheat_prewarning_flag   = 1'b0;
    end
    if (prewarn_evt) begin
      st_next.overheat_prewarning_flag = 1'b1;
    end
    if (|module_overheat_evt) begin
      st_next.first_level_overheat_flag = 1'b1;
    end
    if (overheat2_evt) begin
      st_next.second_level_overheat_flag = 1'b1;
      st_next.fail_safe                  = 1'b1;
    end else if (overheat2_recover) begin
      st_next.fail_safe = 1'b0;
    end
    if (safe_set) begin
      st_next.overheat_safe_state_flag = 1'b1;
    end

    // Consecutive run counter saturates so it can never wrap back below the limit
    if (overheat2_chain_break) begin
      st_next.overheat2_run = 5'h00;
    end else if (overheat2_evt && st_reg.overheat2_run != 5'h1f) begin
      st_next.overheat2_run = st_reg.overheat2_run + 5'h01;
    end

    st_next.module_off = module_off_next;

    st_next.development_mode_flag = development_mode;
    st_next.crc_enabled           = crc_enabled;

    // Device info flags of read-and-clear type
    if (clr_devinfo) begin
      st_next.crc_fail = 1'b0;
      st_next.prior_state = `TDS_PRE_CLEARED;
      st_next.spi_fail = 1'b0;
      st_next.failure  = 1'b0;
    end
    if (crc_error_evt && !crc_toggle_seq) begin
      st_next.crc_fail = 1'b1;
    end
    if (prior_fail_evt) begin
      st_next.prior_state = `TDS_PRE_RESTART;
    end else if (prior_sleep_evt) begin
      st_next.prior_state = `TDS_PRE_SLEEP;
    end
    if (spi_invalid_evt) begin
      st_next.spi_fail = 1'b1;
    end
    if (failure_evt) begin
      st_next.failure = 1'b1;
    end

    // Watchdog count is read-only to the master and ignores the clear access
    // device clears count
    if (wd_count_clr) begin
      st_next.watchdog_failure_count = 2'h0;
    end else if (watchdog_failure_count_evt && !wd_count_dec) begin
      if (st_reg.watchdog_failure_count != `TDS_WD_MAX) begin
        st_next.watchdog_failure_count = st_reg.watchdog_failure_count + 2'h1;
      end
    end else if (wd_count_dec && !watchdog_failure_count_evt) begin
      if (st_reg.watchdog_failure_count != 2'h0) begin
        st_next.watchdog_failure_count = st_reg.watchdog_failure_count - 2'h1;
      end
    end

    // device info reset types
    // Restart keeps every stored flag; only the module shutdowns in module_off drop, so every module comes back on
    if (wipe) begin
      st_next.overheat_safe_state_flag   = 1'b0;
      st_next.second_level_overheat_flag = 1'b0;
      st_next.first_level_overheat_flag  = 1'b0;
      st_next.overheat_prewarning_flag   = 1'b0;
      st_next.crc_fail                   = 1'b0;
      st_next.prior_state                = `TDS_PRE_CLEARED;
      st_next.watchdog_failure_count     = 2'h0;
      st_next.spi_fail                   = 1'b0;
      st_next.failure                    = 1'b0;
      st_next.overheat2_run              = 5'h00;
      st_next.module_off                 = '0;
      st_next.fail_safe                  = 1'b0;
    end else if (restart) begin
      st_next.module_off = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Long wait picks up the safe decision of this very event, not the stale flag
  tds_recovery_timer #(
    .SHORT_WAIT_CYC (SHORT_WAIT_CYC),
    .LONG_WAIT_CYC  (LONG_WAIT_CYC)
  ) u_timer (
    .clk      (clk),
    .rst      (rst | soft_reset),
    .start    (overheat2_evt),
    .long_sel (safe_set | st_reg.overheat_safe_state_flag),
    .done     (overheat2_recover)
  );

  assign rd_data             = st_reg.rd_data;
  assign rd_valid            = st_reg.rd_valid;
  assign module_off          = st_reg.module_off;
  assign fail_safe_req       = st_reg.fail_safe;
  assign overheat2_long_wait = st_reg.overheat_safe_state_flag;

endmodule : tds_thermal_status

/* File: hdl/tds_thermal_status_regs.svh */
// Register offsets, field positions, reset values and timing counts for the status bank
// Function
// - Reserved bits always read as zero
// - Over 16 second-level events sets safe flag
// - Second-level overheat sets flag, enters fail-safe
// - First-level overheat flag, disable affected module only
// - Prewarning condition sets prewarning flag
// - Thermal flags stay until cleared or reset
// - Thermal reset clears all; restart keeps flags
// - Bit 9 shows CRC enable state
// - CRC error on frame sets CRC flag
// - CRC enable/disable sequence leaves CRC flag
// - Bits 7:6 encode pre-restart state
// - Bit 4 mirrors development mode, not writable
// - Watchdog failure count saturates at three
// - Invalid serial command sets SPI failure flag
// - Failure flag set and held until cleared
// - Device alone decrements or clears watchdog count
// - SPI failure flag cleared only by master
// - Device info read ignores frame CRC field
`ifndef TDS_THERMAL_STATUS_REGS_SVH
`define TDS_THERMAL_STATUS_REGS_SVH

`define TDS_ADDR_W             7
`define TDS_OFF_THERMAL        7'h41
`define TDS_OFF_DEVINFO        7'h42

`define TDS_THERM_SAFE_BIT     3
`define TDS_THERM_SECOND_LEVEL_OVERHEAT_FLAG_BIT     2
`define TDS_THERM_FIRST_LEVEL_OVERHEAT_FLAG_BIT     1
`define TDS_THERM_PREW_BIT     0

`define TDS_DEV_CRC_EN_BIT     9
`define TDS_DEV_CRC_FAIL_BIT   8
`define TDS_DEV_PRE_HI         7
`define TDS_DEV_PRE_LO         6
`define TDS_DEV_DEVMODE_BIT    4
`define TDS_DEV_WD_HI          3
`define TDS_DEV_WD_LO          2
`define TDS_DEV_SPI_FAIL_BIT   1
`define TDS_DEV_FAILURE_BIT    0

`define TDS_THERMAL_RESET      16'h0000
`define TDS_DEVINFO_RESET      16'h0000

`define TDS_PRE_CLEARED        2'h0
`define TDS_PRE_RESTART        2'h1
`define TDS_PRE_SLEEP          2'h2

`define TDS_WD_MAX             2'h3
`define TDS_OVERHEAT_SAFE_STATE_FLAG_LIMIT    5'h10

`define TDS_CLK_HZ             32'd25000000
`define TDS_LONG_WAIT_S        32'd64
`define TDS_SHORT_WAIT_MS      32'd1000
`define TDS_LONG_WAIT_CYC      (`TDS_LONG_WAIT_S * `TDS_CLK_HZ)
`define TDS_SHORT_WAIT_CYC     (`TDS_SHORT_WAIT_MS * (`TDS_CLK_HZ / 32'd1000))

`endif

/* File: hdl/tds_pkg.sv */
// Types shared by the thermal and device status bank
package tds_pkg;

  typedef enum logic [1:0] {
    TDS_WAIT_IDLE  = 2'b00,
    TDS_WAIT_SHORT = 2'b01,
    TDS_WAIT_LONG  = 2'b10
  } tds_wait_state_type;

  typedef struct packed {
    tds_wait_state_type state;
    logic [31:0]        count;
    logic               done;
  } tds_wait_type;

endpackage : tds_pkg

/* File: hdl/tds_recovery_timer.sv */
// Wait timer before a second-level overheat recovery attempt
`timescale 1ns/10ps
`include "tds_thermal_status_regs.svh"
module tds_recovery_timer #(
  parameter logic [31:0] SHORT_WAIT_CYC = `TDS_SHORT_WAIT_CYC,
  parameter logic [31:0] LONG_WAIT_CYC  = `TDS_LONG_WAIT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic long_sel,
  output logic      done
);

  tds_pkg::tds_wait_type wait_reg;
  tds_pkg::tds_wait_type wait_next;

  always_comb begin
    wait_next      = wait_reg;
    wait_next.done = 1'b0;
    // A fresh event restarts the wait from its full length
    if (start) begin
      if (long_sel) begin
        wait_next.state = tds_pkg::TDS_WAIT_LONG;
        wait_next.count = LONG_WAIT_CYC - 32'd1;
      end else begin
        wait_next.state = tds_pkg::TDS_WAIT_SHORT;
        wait_next.count = SHORT_WAIT_CYC - 32'd1;
      end
    end else begin
      case (wait_reg.state)
        tds_pkg::TDS_WAIT_IDLE: begin
          wait_next.count = 32'h0;
        end
        tds_pkg::TDS_WAIT_SHORT,
        tds_pkg::TDS_WAIT_LONG: begin
          if (wait_reg.count == 32'h0) begin
            wait_next.state = tds_pkg::TDS_WAIT_IDLE;
            wait_next.done  = 1'b1;
          end else begin
            wait_next.count = wait_reg.count - 32'd1;
          end
        end
        default: begin
          wait_next.state = tds_pkg::TDS_WAIT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_reg <= '{state: tds_pkg::TDS_WAIT_IDLE, count: 32'h0, done: 1'b0};
    end else begin
      wait_reg <= wait_next;
    end
  end

  assign done = wait_reg.done;

endmodule : tds_recovery_timer

/* File: bench/tds_status_sva.sv */
// Concurrent checks on the status bank ports
`timescale 1ns/10ps
module tds_status_sva #(
  parameter int NMOD = 3
) (
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            soft_reset,
  input wire logic            restart,
  input wire logic            acc_valid,
  input wire logic [6:0]      acc_addr,
  input wire logic            acc_crc_bad,
  input wire logic [15:0]     rd_data,
  input wire logic            rd_valid,
  input wire logic [NMOD-1:0] module_overheat_evt,
  input wire logic            overheat2_evt,
  input wire logic            crc_enabled,
  input wire logic            development_mode,
  input wire logic [NMOD-1:0] module_off,
  input wire logic            fail_safe_req,
  input wire logic            overheat2_recover,
  input wire logic            overheat2_long_wait
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || soft_reset);
  logic took;
  // Bad frame check only spares the device information register
  assign took = acc_valid && (!acc_crc_bad || acc_addr == 7'h42);
  chk_answer_time: assert property (took |=> rd_valid)
    else $error("access not answered");
  chk_refuse_quiet: assert property (!took |=> !rd_valid)
    else $error("answer without access");
  chk_therm_resv: assert property (rd_valid && $past(acc_addr) == 7'h41
    |-> rd_data[15:4] == 12'h000) else $error("thermal reserved bits set");
  chk_dev_resv: assert property (rd_valid && $past(acc_addr) == 7'h42
    |-> rd_data[15:10] == 6'h00 && !rd_data[5]) else $error("device reserved bits set");
  chk_unmapped_zero: assert property (rd_valid && $past(acc_addr) != 7'h41
    && $past(acc_addr) != 7'h42 |-> rd_data == 16'h0000) else $error("unmapped data");
  chk_crc_mirror: assert property (rd_valid && $past(acc_addr) == 7'h42 && !$past(rst, 2)
    && !$past(soft_reset, 2) |-> rd_data[9] == $past(crc_enabled, 2))
    else $error("crc state bit wrong");
  chk_devmode_mirror: assert property (rd_valid && $past(acc_addr) == 7'h42
    && !$past(rst, 2) && !$past(soft_reset, 2) |-> rd_data[4] == $past(development_mode, 2))
    else $error("development mode bit wrong");
  chk_safe_wait: assert property (rd_valid && $past(acc_addr) == 7'h41
    |-> rd_data[3] == $past(overheat2_long_wait)) else $error("safe flag and wait differ");
  chk_fail_safe: assert property (overheat2_evt && !overheat2_recover |=> fail_safe_req)
    else $error("no fail-safe request");
  chk_module_off: assert property (module_overheat_evt[0] && !restart |=> module_off[0])
    else $error("module not disabled");
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !rd_valid
    && module_off == '0 && !fail_safe_req && !overheat2_long_wait)
    else $error("outputs not cleared by reset");
endmodule : tds_status_sva

bind tds_thermal_status tds_status_sva #(.NMOD(NMOD)) u_sva (
  .clk(clk), .rst(rst), .soft_reset(soft_reset), .restart(restart), .acc_valid(acc_valid),
  .acc_addr(acc_addr), .acc_crc_bad(acc_crc_bad), .rd_data(rd_data), .rd_valid(rd_valid),
  .module_overheat_evt(module_overheat_evt), .overheat2_evt(overheat2_evt),
  .crc_enabled(crc_enabled), .development_mode(development_mode), .module_off(module_off),
  .fail_safe_req(fail_safe_req), .overheat2_recover(overheat2_recover),
  .overheat2_long_wait(overheat2_long_wait)
);

/* File: bench/tds_spi_master.sv */
// Serial master model issuing decoded register frames
`timescale 1ns/10ps
module tds_spi_master (
  input  wire logic        clk,
  output logic             acc_valid,
  output logic [6:0]       acc_addr,
  output logic             acc_clear,
  output logic             acc_crc_bad,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid
);
  initial begin
    acc_valid   = 1'b0;
    acc_addr    = 7'h00;
    acc_clear   = 1'b0;
    acc_crc_bad = 1'b0;
  end
  task automatic access(input logic v, input logic [6:0] a, input logic c, input logic b,
                        output logic got_v, output logic [15:0] got_d);
    acc_valid   <= v;
    acc_addr    <= a;
    acc_clear   <= c;
    acc_crc_bad <= b;
    @(posedge clk);
    acc_valid   <= 1'b0;
    // Released qualifiers flip so stale values are never mistaken for a frame
    acc_addr    <= ~a;
    acc_clear   <= ~c;
    acc_crc_bad <= ~b;
    #1;
    got_v = rd_valid;
    got_d = rd_data;
  endtask : access
endmodule : tds_spi_master

/* File: bench/tb_thermal_and_device_status_regs.sv */
// Self-checking bench for the thermal and device status bank
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_thermal_and_device_status_regs;
  logic        clk, rst, soft_reset, restart, gv, acc_valid, acc_clear, acc_crc_bad, rd_valid;
  logic        fail_safe_req, overheat2_recover, overheat2_long_wait;
  logic [1:0]  lv;
  logic [2:0]  module_off;
  logic [6:0]  acc_addr;
  logic [15:0] rd_data, gd;
  logic [17:0] ev, m;
  logic [31:0] r;
  int          error_cnt, total_checks, th, crc_f, pre, wd, spi, fl, run, crc_p, dm_p, moff, i;

  tds_thermal_status #(.NMOD(3), .SHORT_WAIT_CYC(32'h14), .LONG_WAIT_CYC(32'h32)) u_dut (
    .clk(clk), .rst(rst), .soft_reset(soft_reset), .restart(restart),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_clear(acc_clear),
    .acc_crc_bad(acc_crc_bad), .rd_data(rd_data), .rd_valid(rd_valid),
    .prewarn_evt(ev[0]), .module_overheat_evt(ev[3:1]), .module_reenable(ev[17:15]),
    .overheat2_evt(ev[4]), .overheat2_chain_break(ev[5]), .crc_enabled(lv[0]),
    .crc_error_evt(ev[6]), .crc_toggle_seq(ev[7]), .prior_fail_evt(ev[8]),
    .prior_sleep_evt(ev[9]), .development_mode(lv[1]), .watchdog_failure_count_evt(ev[10]),
    .wd_count_dec(ev[11]), .wd_count_clr(ev[12]), .spi_invalid_evt(ev[13]),
    .failure_evt(ev[14]), .module_off(module_off), .fail_safe_req(fail_safe_req),
    .overheat2_recover(overheat2_recover), .overheat2_long_wait(overheat2_long_wait)
  );
  tds_spi_master u_mst (
    .clk(clk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_clear(acc_clear),
    .acc_crc_bad(acc_crc_bad), .rd_data(rd_data), .rd_valid(rd_valid)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic zero();
    th = 0;
    crc_f = 0;
    pre = 0;
    wd = 0;
    spi = 0;
    fl = 0;
    run = 0;
    moff = 0;
  endtask : zero

  function automatic logic [15:0] dev_word();
    return {6'h00, 1'(crc_p), 1'(crc_f), 2'(pre), 1'b0, 1'(dm_p), 2'(wd), 1'(spi), 1'(fl)};
  endfunction : dev_word

  // One frame with events landing on the same edge; levels show up one frame later
  task automatic op(input logic v, input logic [6:0] a, input logic c, input logic b,
                    input logic [17:0] e, input logic [1:0] l);
    logic [15:0] ex;
    ex = (a == 7'h41) ? 16'(th) : ((a == 7'h42) ? dev_word() : 16'h0000);
    @(posedge clk);
    ev <= e;
    lv <= l;
    fork
      u_mst.access(v, a, c, b, gv, gd);
      begin @(posedge clk); ev <= '0; end
    join
    `CHK(gv, 1'(v && (!b || a == 7'h42)))
    if (gv === 1'b1) `CHK(gd, ex)
    // clear before set so a coincident event survives
    if (gv === 1'b1 && c && a == 7'h41) th = 0;
    if (gv === 1'b1 && c && a == 7'h42) begin crc_f = 0; pre = 0; spi = 0; fl = 0; end
    if (e[0]) th |= 1;
    if (e[3:1] != 3'h0) th |= 2;
    if (e[4]) begin th |= (run >= 16) ? 12 : 4; run++; end
    if (e[5]) run = 0;
    if (e[6] && !e[7]) crc_f = 1;
    if (e[8]) pre = 1; else if (e[9]) pre = 2;
    if (e[13]) spi = 1;
    if (e[14]) fl = 1;
    if (e[12]) wd = 0; else if (e[10] && !e[11] && wd < 3) wd++;
    else if (e[11] && !e[10] && wd > 0) wd--;
    moff = (moff & ~int'(e[17:15])) | int'(e[3:1]);
    crc_p = l[0];
    dm_p = l[1];
    `CHK(module_off, 3'(moff))
    `CHK(overheat2_long_wait, 1'(th >> 3))
  endtask : op

  initial begin
    rst = 1'b1;
    soft_reset = 1'b0;
    restart = 1'b0;
    ev = '0;
    lv = '0;
    m = '0;
    error_cnt = 0;
    total_checks = 0;
    crc_p = 0;
    dm_p = 0;
    zero();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    r = $urandom(32'h24c9);
    op(1, 7'h41, 0, 0, '0, 2'b11);
    op(1, 7'h42, 0, 1, '0, 2'b11);
    op(1, 7'h41, 1, 1, 18'h00001, 2'b10);
    op(1, 7'h40, 0, 0, '0, 2'b01);
    for (i = 0; i < 4; i++) op(0, 7'h42, 0, 0, 18'h00400, 2'b01);
    for (i = 0; i < 17; i++) op(1, 7'h41, 0, 0, 18'h00010, 2'b01);
    `CHK(fail_safe_req, 1'b1)
    i = 0;
    do begin @(posedge clk); #1; i++; end while (overheat2_recover !== 1'b1 && i < 100);
    if (i >= 100) begin error_cnt++; $display("BAD t=%0t no recovery", $time); end
    if (i >= 100) tally_and_finish();
    `CHK(i, 50)
    @(posedge clk);
    #1;
    `CHK(fail_safe_req, 1'b0)
    op(1, 7'h41, 1, 0, 18'h0000f, 2'b00);
    op(1, 7'h42, 1, 0, 18'h07140, 2'b00);
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    moff = 0;
    op(1, 7'h41, 0, 0, '0, 2'b00);
    op(1, 7'h42, 0, 0, '0, 2'b00);
    for (i = 0; i < 400; i++) begin
      r = $urandom;
      m = 18'($urandom & $urandom & $urandom);
      if (m[4]) m[5] = 1'b0;
      op(r[0] | r[1], (r[3:2] == 2'd3) ? 7'h40 : (r[2] ? 7'h42 : 7'h41), r[4],
         r[7:5] == 3'd0, m, r[9:8]);
    end
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    zero();
    op(1, 7'h41, 0, 0, '0, 2'b00);
    op(1, 7'h42, 0, 0, '0, 2'b00);
    tally_and_finish();
  end
endmodule : tb_thermal_and_device_status_regs
